// File: hdl/ief_irq_bank.sv
// interrupt enable and flag register bank with core vectoring
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module ief_irq_bank
  import ief_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // asynchronous pins
  input wire logic ext_pin,
  input wire logic [7:0] port_pins,
  // peripheral events on this clock
  input wire ief_evt_s evt,
  input wire logic [7:0] usart_rx_data,
  // peripheral side effects
  output logic usart_rx_pop,
  output logic usart_tx_push,
  output logic [7:0] usart_tx_data,
  // core vectoring
  input wire logic return_from_isr,
  output ief_core_s core
);

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a[5:2] == o[5:2]);
  endfunction

  // hardware set wins over a software write in the same cycle
  function automatic logic [7:0] flags(input logic [7:0] q,
      input logic [7:0] set, input logic wr, input logic [7:0] wv);
    flags = set | (wr ? wv : q);
  endfunction

  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] ctrl_q, opt_q, pe1_q, pr1_q, ioc_q, t0_cnt_q, tx_q;
  logic pe2_q, pr2_q;
  logic rx_pop_q, tx_push_q;
  logic ext_s1, ext_s2, ext_s3;
  logic [7:0] pin_s1, pin_s2, pin_s3;
  logic [1:0] lat_q;
  ief_vec_e vs_q;

  // bus decode
  wire req = avs_read | avs_write;
  wire done = req & ack_q;
  wire [7:0] wv = avs_writedata[7:0];
  wire wr = avs_write & ack_q & avs_byteenable[0];
  wire sel_ctrl = hit(avs_address, OFS_CTRL);
  wire sel_opt = hit(avs_address, OFS_OPT);
  wire sel_pe1 = hit(avs_address, OFS_PE1);
  wire sel_pe2 = hit(avs_address, OFS_PE2);
  wire sel_pr1 = hit(avs_address, OFS_PR1);
  wire sel_pr2 = hit(avs_address, OFS_PR2);
  wire sel_ioc = hit(avs_address, OFS_IOC);
  wire sel_t0 = hit(avs_address, OFS_T0);
  wire sel_rxd = hit(avs_address, OFS_RXD);
  wire sel_txd = hit(avs_address, OFS_TXD);
  wire sel_core = hit(avs_address, OFS_CORE);
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_pr1 = wr & sel_pr1;
  wire wr_pr2 = wr & sel_pr2;

  // event detection
  wire ext_rise = ext_s2 & ~ext_s3;
  wire ext_fall = ~ext_s2 & ext_s3;
  wire ext_hit = opt_q[B_EDGE] ? ext_rise : ext_fall;
  wire [7:0] pin_chg = (pin_s2 ^ pin_s3) & ioc_q;
  wire pc_set = |pin_chg;
  wire t0_set = evt.timer0_tick & (t0_cnt_q == T0_TOP);
  wire cc1_set = evt.ccp1_event & (evt.ccp1_mode != CCP_PWM);
  wire cc2_set = evt.ccp2_event & (evt.ccp2_mode != CCP_PWM);

  // flags set independent of the interrupt enables; pin change is masked by ioc_q
  wire [7:0] ctrl_set = {5'h00, t0_set, ext_hit, pc_set};
  wire [7:0] pr1_set = {1'b0, evt.adc_done, 2'h0, evt.ssp_done,
                        cc1_set, evt.t2_match, evt.t1_ovf};
  wire [7:0] ctrl_fl = flags(ctrl_q & CTRL_FLAGS, ctrl_set, wr_ctrl,
                             wv & CTRL_FLAGS);
  wire [7:0] pr1_fl = flags(pr1_q, pr1_set, wr_pr1, wv) & PR1_STICKY;
  wire [7:0] pr2_fl = flags({7'h00, pr2_q}, {7'h00, cc2_set}, wr_pr2, wv);

  // live view of request-one: gate, rx and tx are levels
  wire [7:0] pr1_v = {~evt.t1_gate_active, pr1_q[6], evt.rx_full,
                      evt.tx_empty, pr1_q[3:0]};

  // request to the core
  wire core_hit = |(ctrl_q[5:3] & ctrl_q[2:0]);
  wire per_hit = |(pe1_q & pr1_v) | (pe2_q & pr2_q);
  wire irq_req = ctrl_q[B_GIE] &
                 (core_hit | (ctrl_q[B_PERIPHERAL_IRQ_GATE] & per_hit));
  wire take = (vs_q == VS_TAKE);

  // global enable: vector clears, return sets, else software
  wire gie_d = take ? 1'b0 :
               return_from_isr ? 1'b1 :
               wr_ctrl ? wv[B_GIE] : ctrl_q[B_GIE];
  wire [7:0] ctrl_d = {gie_d,
                       wr_ctrl ? wv[6:3] : ctrl_q[6:3], ctrl_fl[2:0]};

  // read mux
  wire [7:0] rd_mux =
    sel_ctrl ? ctrl_q :
    sel_opt ? opt_q :
    sel_pe1 ? pe1_q :
    sel_pe2 ? {7'h00, pe2_q} :
    sel_pr1 ? pr1_v :
    sel_pr2 ? {7'h00, pr2_q} :
    sel_ioc ? ioc_q :
    sel_t0 ? t0_cnt_q :
    sel_rxd ? usart_rx_data :
    sel_txd ? tx_q :
    sel_core ? {5'h00, irq_req, vs_q} : 8'h00;

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = {24'h000000, rdata_q};
  assign usart_rx_pop = rx_pop_q;
  assign usart_tx_push = tx_push_q;
  assign usart_tx_data = tx_q;
  assign core.request = irq_req;
  assign core.vector_take = take;
  assign core.flush = take;
  assign core.vector_addr = VEC_ADDR;

  // bus handshake: one wait state per access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      rx_pop_q <= 1'b0;
      tx_push_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q)
        rdata_q <= rd_mux;
      rx_pop_q <= done & avs_read & sel_rxd;
      tx_push_q <= wr & sel_txd;
    end
  end

  // pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end else begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      pin_s1 <= port_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // registers and flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      opt_q <= OPT_RST;
      pe1_q <= PE_RST;
      pe2_q <= 1'b0;
      pr1_q <= FLAG_RST;
      pr2_q <= 1'b0;
      ioc_q <= IOC_RST;
      tx_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      pr1_q <= pr1_fl;
      pr2_q <= pr2_fl[B_CC2F];
      if (wr & sel_opt)
        opt_q <= wv;
      if (wr & sel_pe1)
        pe1_q <= wv;
      if (wr & sel_pe2)
        pe2_q <= wv[0];
      if (wr & sel_ioc)
        ioc_q <= wv;
      if (wr & sel_txd)
        tx_q <= wv;
    end
  end

  // timer0 count keeps its value through reset
  always_ff @(posedge ref_clk) begin
    if (wr & sel_t0)
      t0_cnt_q <= wv;
    else if (evt.timer0_tick)
      t0_cnt_q <= t0_cnt_q + 8'h01;
  end

  // vectoring sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vs_q <= VS_IDLE;
      lat_q <= 2'h0;
    end else begin
      case (vs_q)
        VS_IDLE: begin
          lat_q <= 2'h1;
          if (irq_req)
            vs_q <= VS_WAIT;
        end
        VS_WAIT: begin
          lat_q <= lat_q + 2'h1;
          if (!irq_req)
            vs_q <= VS_IDLE;
          else if (lat_q == LAT_LAST)
            vs_q <= VS_TAKE;
        end
        VS_TAKE: begin
          vs_q <= VS_IDLE;
        end
        default: begin
          vs_q <= VS_IDLE;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_gie_blocks_req: assert property (
    !ctrl_q[B_GIE] |-> !core.request)
    else $error("request with global enable clear");

  a_peripheral_irq_gate_gates_per: assert property (
    !ctrl_q[B_PERIPHERAL_IRQ_GATE] && !core_hit |-> !core.request)
    else $error("peripheral request passed closed gate");

  a_t2_flag_sets: assert property (
    evt.t2_match |=> pr1_q[1])
    else $error("timer2 flag not set on match");

  a_t0_rollover: assert property (
    evt.timer0_tick && t0_cnt_q == T0_TOP && !(wr & sel_t0)
    |=> ctrl_q[B_T0F] && t0_cnt_q == 8'h00)
    else $error("timer0 rollover missed");

  a_ext_edge_sel: assert property (
    $rose(ext_s2) && opt_q[B_EDGE] |=> ctrl_q[B_EXT_PIN_IRQ_FLAG])
    else $error("rising edge did not set pin flag");

  a_pin_masked: assert property (
    !ctrl_q[B_PCF] && pin_chg == 8'h00 && !wr_ctrl |=> !ctrl_q[B_PCF])
    else $error("change flag set by masked pin");

  a_pe2_upper_zero: assert property (
    avs_read && !ack_q && sel_pe2 |=> avs_readdata[7:1] == 7'h00)
    else $error("enable-two upper bits not zero");

  a_rx_read_pops: assert property (
    avs_read && !avs_waitrequest && sel_rxd |=> usart_rx_pop)
    else $error("rx data read gave no pop");

  a_tx_write_push: assert property (
    avs_write && !avs_waitrequest && avs_byteenable[0] && sel_txd
    |=> usart_tx_push && usart_tx_data == $past(wv))
    else $error("tx data write gave no push");

  a_ccp_pwm_quiet: assert property (
    evt.ccp1_event && evt.ccp1_mode == CCP_PWM && !pr1_q[2] && !wr_pr1
    |=> !pr1_q[2])
    else $error("cc1 flag set in pwm mode");

  a_vec_latency: assert property (
    vs_q == VS_IDLE && core.request ##1 core.request [*2]
    |=> core.vector_take && core.vector_addr == VEC_ADDR)
    else $error("vector not taken after three cycles");

  a_take_clears_gie: assert property (
    core.vector_take |=> !ctrl_q[B_GIE] && !core.vector_take)
    else $error("global enable not cleared on vector");

  a_return_sets_gie: assert property (
    return_from_isr && !core.vector_take |=> ctrl_q[B_GIE])
    else $error("return did not set global enable");

  a_adc_flag_sets: assert property (
    evt.adc_done |=> pr1_q[6])
    else $error("conversion flag not set on completion");

  a_adc_flag_holds: assert property (
    pr1_q[6] && !wr_pr1 |=> pr1_q[6])
    else $error("conversion flag dropped without a write");

  a_ssp_flag_sets: assert property (
    evt.ssp_done |=> pr1_q[3])
    else $error("serial port flag not set on completion");

  a_t1_ovf_sets: assert property (
    evt.t1_ovf |=> pr1_q[0])
    else $error("timer1 overflow flag not set");

  a_cc1_flag_sets: assert property (
    evt.ccp1_event && evt.ccp1_mode != CCP_PWM |=> pr1_q[2])
    else $error("cc1 flag not set on capture or compare");

  a_cc2_flag_sets: assert property (
    evt.ccp2_event && evt.ccp2_mode != CCP_PWM |=> pr2_q)
    else $error("cc2 flag not set on capture or compare");

  a_ext_fall_sets: assert property (
    $fell(ext_s2) && !opt_q[B_EDGE] |=> ctrl_q[B_EXT_PIN_IRQ_FLAG])
    else $error("falling edge did not set pin flag");

  a_pin_chg_sets: assert property (
    pin_chg != 8'h00 |=> ctrl_q[B_PCF])
    else $error("enabled pin change did not set flag");

  a_pin_flag_holds: assert property (
    ctrl_q[B_EXT_PIN_IRQ_FLAG] && !wr_ctrl |=> ctrl_q[B_EXT_PIN_IRQ_FLAG])
    else $error("pin flag dropped without a write");

  a_gate_flag_live: assert property (
    avs_read && !ack_q && sel_pr1
    |=> avs_readdata[7] == !$past(evt.t1_gate_active))
    else $error("gate flag does not show inactive gate");

  a_core_pair_req: assert property (
    ctrl_q[B_GIE] && core_hit |-> core.request)
    else $error("enabled core source gave no request");

  a_per_pair_req: assert property (
    ctrl_q[B_GIE] && ctrl_q[B_PERIPHERAL_IRQ_GATE] && per_hit |-> core.request)
    else $error("enabled peripheral source gave no request");

  c_vector_taken: cover property (core.vector_take);
  c_ext_pin_hit: cover property (ext_hit && ctrl_q[4]);
  c_rx_pop: cover property (usart_rx_pop && evt.rx_full);
  c_set_beats_clr: cover property (wr_pr1 && evt.t1_ovf && !wv[0]);
  c_fall_edge_hit: cover property ($fell(ext_s2) && !opt_q[B_EDGE]);

endmodule

// File: hdl/ief_pkg.sv
// shared constants and types for the interrupt enable and flag bank
package ief_pkg;
  // register byte offsets on the avalon bus
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_OPT = 6'h04;
  localparam logic [5:0] OFS_PE1 = 6'h08;
  localparam logic [5:0] OFS_PE2 = 6'h0c;
  localparam logic [5:0] OFS_PR1 = 6'h10;
  localparam logic [5:0] OFS_PR2 = 6'h14;
  localparam logic [5:0] OFS_IOC = 6'h18;
  localparam logic [5:0] OFS_T0 = 6'h1c;
  localparam logic [5:0] OFS_RXD = 6'h20;
  localparam logic [5:0] OFS_TXD = 6'h24;
  localparam logic [5:0] OFS_CORE = 6'h28;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'hff;
  localparam logic [7:0] PE_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] IOC_RST = 8'h00;
  // field positions
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_IRQ_GATE = 6;
  localparam int B_T0F = 2;
  localparam int B_EXT_PIN_IRQ_FLAG = 1;
  localparam int B_PCF = 0;
  localparam int B_EDGE = 6;
  localparam int B_CC2F = 0;
  // request-one bits kept as sticky flags, the rest are live levels
  localparam logic [7:0] PR1_STICKY = 8'h4f;
  // control flags in the low three bits of the control register
  localparam logic [7:0] CTRL_FLAGS = 8'h07;
  localparam logic [7:0] T0_TOP = 8'hff;
  // vector address and latency in instruction cycles
  localparam logic [12:0] VEC_ADDR = 13'h0004;
  localparam int LAT_TCY = 3;
  localparam int CYC_PER_TCY = 1;
  localparam int LAT_CYC = LAT_TCY * CYC_PER_TCY;
  localparam logic [1:0] LAT_LAST = 2'(LAT_CYC - 1);

  typedef enum logic [1:0] {
    CCP_CAPTURE = 2'h0,
    CCP_COMPARE = 2'h1,
    CCP_PWM = 2'h2
  } ief_ccp_e;

  typedef enum logic [1:0] {
    VS_IDLE = 2'h0,
    VS_WAIT = 2'h1,
    VS_TAKE = 2'h3
  } ief_vec_e;

  typedef struct packed {
    logic timer0_tick;
    logic t1_gate_active;
    logic adc_done;
    logic rx_full;
    logic tx_empty;
    logic ssp_done;
    logic ccp1_event;
    ief_ccp_e ccp1_mode;
    logic t2_match;
    logic t1_ovf;
    logic ccp2_event;
    ief_ccp_e ccp2_mode;
  } ief_evt_s;

  typedef struct packed {
    logic request;
    logic vector_take;
    logic flush;
    logic [12:0] vector_addr;
  } ief_core_s;
endpackage

// File: tb/ief_periph_model.sv
// peripheral event sources and core return strobe facing the bank
`timescale 1ns/1ps
module ief_periph_model
  import ief_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // side effects from the bank
  input wire logic usart_rx_pop,
  input wire logic usart_tx_push,
  // event sources and core
  output ief_evt_s evt,
  output logic ext_pin,
  output logic [7:0] port_pins,
  output logic [7:0] usart_rx_data,
  output logic return_from_isr
);
  logic [2:0] tx_busy_q;

  initial begin
    evt = '0;
    evt.t1_gate_active = 1'b1;
    ext_pin = 1'b0;
    port_pins = 8'h00;
    usart_rx_data = 8'h3c;
    return_from_isr = 1'b0;
    tx_busy_q = 3'h0;
  end

  // receiver empties on a data read, transmitter drains a few cycles later
  always @(posedge ref_clk) begin
    if (usart_rx_pop) begin
      evt.rx_full <= 1'b0;
    end
    if (usart_tx_push) begin
      evt.tx_empty <= 1'b0;
      tx_busy_q <= 3'h7;
    end else if (tx_busy_q != 3'h0) begin
      tx_busy_q <= tx_busy_q - 3'h1;
      if (tx_busy_q == 3'h1) begin
        evt.tx_empty <= 1'b1;
      end
    end
  end

  // one-cycle pulses: 7 tick, 6 adc, 5 return, 4 cc2, 3 ssp, 2 cc1, 1 t2, 0 t1
  task automatic fire(input logic [7:0] m);
    @(posedge ref_clk);
    evt.timer0_tick <= m[7];
    evt.adc_done <= m[6];
    return_from_isr <= m[5];
    evt.ccp2_event <= m[4];
    evt.ssp_done <= m[3];
    evt.ccp1_event <= m[2];
    evt.t2_match <= m[1];
    evt.t1_ovf <= m[0];
    @(posedge ref_clk);
    {evt.timer0_tick, evt.adc_done, return_from_isr, evt.ccp2_event} <= '0;
    {evt.ssp_done, evt.ccp1_event, evt.t2_match, evt.t1_ovf} <= '0;
  endtask
endmodule

// File: tb/test_irq_enable_flag_bank.sv
// self-checking bench for the interrupt enable and flag bank
`timescale 1ns/1ps
module test_irq_enable_flag_bank
  import ief_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic usart_rx_pop;
  logic usart_tx_push;
  logic [7:0] usart_tx_data;
  logic [7:0] rx_data;
  logic [7:0] port_pins;
  logic ext_pin;
  logic ret;
  ief_evt_s evt;
  ief_core_s core;
  int fails = 0;
  int check_count = 0;
  logic [7:0] r;

  always #5 ref_clk = ~ref_clk;

  ief_irq_bank dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_pin(ext_pin),
    .port_pins(port_pins), .evt(evt), .usart_rx_data(rx_data),
    .usart_rx_pop(usart_rx_pop), .usart_tx_push(usart_tx_push),
    .usart_tx_data(usart_tx_data), .return_from_isr(ret), .core(core)
  );

  ief_periph_model pm (
    .ref_clk(ref_clk), .usart_rx_pop(usart_rx_pop),
    .usart_tx_push(usart_tx_push), .evt(evt), .ext_pin(ext_pin),
    .port_pins(port_pins), .usart_rx_data(rx_data),
    .return_from_isr(ret)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) fails++;
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h00, r}, {8'h00, e});
  endtask

  task automatic t_reset;
    rd(OFS_CTRL, 8'h00);
    rd(OFS_OPT, 8'hff);
    rd(OFS_PE1, 8'h00);
    rd(OFS_PE2, 8'h00);
    rd(OFS_PR1, 8'h00);
    rd(OFS_PR2, 8'h00);
    rd(OFS_CORE, 8'h00);
    rd(6'h2c, 8'h00);
  endtask

  task automatic t_enables;
    wr(OFS_PE1, 8'ha5);
    rd(OFS_PE1, 8'ha5);
    avs_byteenable <= 4'h0;
    wr(OFS_PE1, 8'hff);
    avs_byteenable <= 4'h1;
    rd(OFS_PE1, 8'ha5);
    wr(OFS_PE2, 8'hff);
    rd(OFS_PE2, 8'h01);
    wr(OFS_PE1, 8'h00);
    wr(OFS_PE2, 8'h00);
  endtask

  task automatic t_flags;
    pm.evt.ccp1_mode <= CCP_CAPTURE;
    pm.evt.ccp2_mode <= CCP_COMPARE;
    pm.fire(8'h5f);
    rd(OFS_PR1, 8'h4f);
    rd(OFS_PR2, 8'h01);
    rd(OFS_PR1, 8'h4f);
    wr(OFS_PR1, 8'h00);
    wr(OFS_PR2, 8'h00);
    rd(OFS_PR1, 8'h00);
    rd(OFS_PR2, 8'h00);
    pm.evt.ccp1_mode <= CCP_PWM;
    pm.evt.ccp2_mode <= CCP_PWM;
    pm.fire(8'h14);
    rd(OFS_PR1, 8'h00);
    rd(OFS_PR2, 8'h00);
  endtask

  task automatic t_live;
    pm.evt.t1_gate_active <= 1'b0;
    pm.evt.rx_full <= 1'b1;
    pm.evt.tx_empty <= 1'b1;
    rd(OFS_PR1, 8'hb0);
    rd(OFS_RXD, 8'h3c);
    rd(OFS_PR1, 8'h90);
    wr(OFS_TXD, 8'h77);
    rd(OFS_PR1, 8'h80);
    chk({8'h00, usart_tx_data}, 16'h0077);
    pm.evt.t1_gate_active <= 1'b1;
  endtask

  task automatic t_timer0;
    wr(OFS_T0, 8'hff);
    wr(OFS_CTRL, 8'h00);
    pm.fire(8'h80);
    rd(OFS_CTRL, 8'h04);
    rd(OFS_CTRL, 8'h04);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFS_T0, 8'h00);
    rd(OFS_CTRL, 8'h00);
  endtask

  task automatic t_pins;
    pm.ext_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h02);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_OPT, 8'hbf);
    pm.ext_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h02);
    wr(OFS_CTRL, 8'h00);
    pm.ext_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h00);
    wr(OFS_IOC, 8'h01);
    pm.port_pins <= 8'h01;
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h01);
    wr(OFS_CTRL, 8'h89);
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h09);
    wr(OFS_CTRL, 8'h00);
    pm.port_pins <= 8'h03;
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h00);
  endtask

  task automatic t_vector;
    int n;
    n = 0;
    wr(OFS_PR1, 8'h00);
    wr(OFS_PE1, 8'h40);
    pm.fire(8'h40);
    wr(OFS_CTRL, 8'h40);
    @(negedge ref_clk);
    chk({15'h0, core.request}, 16'h0000);
    wr(OFS_CTRL, 8'h80);
    @(negedge ref_clk);
    chk({15'h0, core.request}, 16'h0000);
    wr(OFS_CTRL, 8'hc0);
    @(negedge ref_clk);
    chk({15'h0, core.request}, 16'h0001);
    while (core.vector_take !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n), 16'(LAT_CYC));
    chk({15'h0, core.flush}, 16'h0001);
    chk({3'h0, core.vector_addr}, 16'h0004);
    @(negedge ref_clk);
    chk({15'h0, core.request}, 16'h0000);
    rd(OFS_CTRL, 8'h40);
    wr(OFS_PR1, 8'h00);
    pm.fire(8'h20);
    rd(OFS_CTRL, 8'hc0);
    wr(OFS_CTRL, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_enables;
    t_flags;
    t_live;
    t_timer0;
    t_pins;
    t_vector;
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test;
  end
endmodule
